/* core/dpram_pkg.sv */
// Shared sizes and reset values for the synchronous dual-port RAM port
package dpram_pkg;
	localparam int             ADDR_W   = 15;      // 32K words
	localparam int             DATA_W   = 18;      // Two 9-bit bytes
	localparam int             BYTE_W   = 9;
	localparam int             BYTES    = 2;
	localparam int             DEPTH    = 32768;
	localparam logic [14:0]    ADDR_RST = 15'h0000; // Counter reset value
	localparam logic [17:0]    DATA_RST = 18'h00000;
	localparam logic [1:0]     EN_RST   = 2'h0;
endpackage

/* core/ram_cells.sv */
// Dual-port storage array with byte writes and registered reads
`timescale 1ns/1ps
module ram_cells
	import dpram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter int BW = BYTE_W
) (
	// Clock
	input  wire logic          mclk,
	// Port A
	input  wire logic          a_rd,
	input  wire logic [1:0]    a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [DW-1:0] a_wdata,
	output logic      [DW-1:0] a_rdata,
	// Port B
	input  wire logic          b_rd,
	input  wire logic [1:0]    b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [DW-1:0] b_wdata,
	output logic      [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Byte writes, port B wins a same-cycle collision
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 2; i++) begin
			if (a_we[i]) begin
				mem[a_addr][i*BW +: BW] <= a_wdata[i*BW +: BW];
			end
		end
		for (int j = 0; j < 2; j++) begin
			if (b_we[j]) begin
				mem[b_addr][j*BW +: BW] <= b_wdata[j*BW +: BW];
			end
		end
	end

	// Registered reads, held when not reading
	always_ff @(posedge mclk) begin
		if (a_rd) begin
			a_rdata <= mem[a_addr];
		end
		if (b_rd) begin
			b_rdata <= mem[b_addr];
		end
	end
endmodule // ram_cells

/* core/sync_dual_port_ram_counter_port.sv */
// One counter port of a synchronous dual-port RAM, plus a plain second port
`timescale 1ns/1ps
// Behaviour
// - All input registers load on the rising clock edge; writes need no clock-low phase.
// - A low load strobe captures the external address as the internal address.
// - Internal address is the external one on load, else the counter output.
// - A low advance input without load steps the address by one and writes go there.
// - Load and advance both high hold the address so read data stays put.
// - An inactive advance input freezes the counter for interleaved use.
// - Counter reset costs no cycle; an access proceeds in the same cycle.
// - Flow-through output drive follows the controls registered in the previous cycle; pipelined, those of two cycles back.
// - The output enable gates the data drivers asynchronously.
// - Either chip select inactive for a cycle puts the port in low power.
// - Pipelined outputs return only after two consecutive selected cycles.
// - Latency select high gives pipelined, low flow-through, acting asynchronously.
// - After the next edge a deselected port floats; a high byte select floats after the next edge in flow-through, two edges when pipelined.
module sync_dual_port_ram_counter_port
	import dpram_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter int BW = BYTE_W
) (
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// Address and counter control
	input  wire logic [AW-1:0] ext_addr,
	input  wire logic          addr_load_strobe_n,
	input  wire logic          count_advance_n,
	input  wire logic          count_clear_n,
	// Access control
	input  wire logic          chip_sel_low_n,
	input  wire logic          chip_sel_high,
	input  wire logic          write_n,
	input  wire logic          upper_byte_sel_n,
	input  wire logic          lower_byte_sel_n,
	input  wire logic          out_enable_n,
	input  wire logic          output_latency_sel,
	// Data pins
	input  wire logic [DW-1:0] data_in,
	output logic      [DW-1:0] data_out,
	output logic      [1:0]    data_oe,
	// Status
	output logic               low_power,
	output logic      [AW-1:0] int_addr,
	// Second port
	input  wire logic          b_rd,
	input  wire logic [1:0]    b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [DW-1:0] b_wdata,
	output logic      [DW-1:0] b_rdata
);
	// Counter and output pipeline state
	logic [AW-1:0] addr_q;
	logic [AW-1:0] addr_d;
	logic [1:0]    en1_q;
	logic [1:0]    en2_q;
	logic          sel1_q;
	logic [DW-1:0] rd1;
	logic [DW-1:0] rd2_q;

	// Access decode and output enable nets
	wire           sel_w;
	wire  [1:0]    byte_w;
	wire           rd_w;
	wire  [1:0]    we_w;
	wire  [1:0]    en_ft;
	wire  [1:0]    en_pipe;

	// Next internal address: clear, load, advance, hold
	assign addr_d = !count_clear_n       ? ADDR_RST :
	                !addr_load_strobe_n  ? ext_addr :
	                !count_advance_n     ? AW'(addr_q + 1'b1) :
	                addr_q;

	// Access decode on the current edge's address
	assign sel_w  = !chip_sel_low_n && chip_sel_high;
	assign byte_w = {!upper_byte_sel_n, !lower_byte_sel_n};
	assign rd_w   = sel_w && write_n;
	assign we_w   = {2{sel_w && !write_n}} & byte_w;

	// Counter and control pipeline, all on the rising edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addr_q <= ADDR_RST;
			en1_q  <= EN_RST;
			en2_q  <= EN_RST;
			sel1_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			en1_q  <= {2{rd_w}} & byte_w;
			en2_q  <= en1_q;
			sel1_q <= sel_w;
		end
	end

	// Second output stage for pipelined mode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd2_q <= DATA_RST;
		end else begin
			rd2_q <= rd1;
		end
	end

	// Storage; write pulse is a plain edge write
	ram_cells #(.AW(AW), .DW(DW), .BW(BW)) u_cells (
		.mclk    (mclk),
		.a_rd    (rd_w),
		.a_we    (we_w),
		.a_addr  (addr_d),
		.a_wdata (data_in),
		.a_rdata (rd1),
		.b_rd    (b_rd),
		.b_we    (b_we),
		.b_addr  (b_addr),
		.b_wdata (b_wdata),
		.b_rdata (b_rdata)
	);

	// Output drive selection
	assign en_ft    = en1_q;
	assign en_pipe  = en2_q & {2{sel1_q}};
	assign data_out = output_latency_sel ? rd2_q : rd1;
	assign data_oe  = (output_latency_sel ? en_pipe : en_ft)
	                  & {2{!out_enable_n}};
	assign low_power = !sel1_q;
	assign int_addr  = addr_q;

	// Checks
	clear_addr_a: assert property (@(posedge mclk) disable iff (rst)
		!count_clear_n |=> addr_q == ADDR_RST)
		else $error("counter clear did not zero the address");
	load_addr_a: assert property (@(posedge mclk) disable iff (rst)
		count_clear_n && !addr_load_strobe_n |=> addr_q == $past(ext_addr))
		else $error("load strobe did not capture the address");
	advance_a: assert property (@(posedge mclk) disable iff (rst)
		count_clear_n && addr_load_strobe_n && !count_advance_n
		|=> addr_q == AW'($past(addr_q) + 1'b1))
		else $error("counter did not advance by one");
	hold_addr_a: assert property (@(posedge mclk) disable iff (rst)
		(count_clear_n && addr_load_strobe_n && count_advance_n) [*2]
		|=> addr_q == $past(addr_q, 2))
		else $error("address moved while held");
	async_oe_a: assert property (@(posedge mclk) disable iff (rst)
		out_enable_n |-> data_oe == 2'h0)
		else $error("drivers on with output enable high");
	desel_float_a: assert property (@(posedge mclk) disable iff (rst)
		!sel_w |=> data_oe == 2'h0 && low_power)
		else $error("deselected port still drives");
	pipe_react_a: assert property (@(posedge mclk) disable iff (rst)
		output_latency_sel && data_oe != 2'h0
		|-> $past(sel_w, 1) && $past(sel_w, 2))
		else $error("pipelined outputs back too early");
	byte_float_a: assert property (@(posedge mclk) disable iff (rst)
		rd_w && upper_byte_sel_n && !lower_byte_sel_n |=> !en1_q[1] && en1_q[0])
		else $error("byte select not honoured");
	ft_drive_a: assert property (@(posedge mclk) disable iff (rst)
		rd_w && !lower_byte_sel_n ##1 !output_latency_sel && !out_enable_n
		|-> data_oe[0])
		else $error("flow-through read did not drive");
	clear_write_a: assert property (@(posedge mclk) disable iff (rst)
		!count_clear_n && sel_w && !write_n && byte_w[0] && !b_we[0]
		|=> u_cells.mem[ADDR_RST][BW-1:0] == $past(data_in[BW-1:0]))
		else $error("access lost in counter clear cycle");

	// Address and storage checks
	load_read_a: assert property (@(posedge mclk) disable iff (rst)
		count_clear_n && !addr_load_strobe_n && rd_w && b_we == 2'h0
		|=> rd1 == u_cells.mem[$past(ext_addr)])
		else $error("read did not use the external address");
	adv_write_a: assert property (@(posedge mclk) disable iff (rst)
		count_clear_n && addr_load_strobe_n && !count_advance_n
		&& we_w[0] && !b_we[0]
		|=> u_cells.mem[addr_q][BW-1:0] == $past(data_in[BW-1:0]))
		else $error("advance write missed the next address");
	stall_addr_a: assert property (@(posedge mclk) disable iff (rst)
		count_clear_n && addr_load_strobe_n && count_advance_n
		|=> int_addr == $past(int_addr))
		else $error("counter moved while stalled");
	clear_prio_a: assert property (@(posedge mclk) disable iff (rst)
		!count_clear_n && !addr_load_strobe_n |=> int_addr == ADDR_RST)
		else $error("load beat the counter clear");
	hold_data_a: assert property (@(posedge mclk) disable iff (rst)
		(count_clear_n && addr_load_strobe_n && count_advance_n
		&& rd_w && b_we == 2'h0) [*2] ##1 !output_latency_sel
		|-> $stable(data_out))
		else $error("read data moved while the address was held");

	// Output checks
	wake_a: assert property (@(posedge mclk) disable iff (rst)
		sel_w |=> !low_power)
		else $error("selected port stayed in low power");
	pipe_data_a: assert property (@(posedge mclk) disable iff (rst)
		output_latency_sel |-> data_out == $past(rd1))
		else $error("pipelined data not one stage late");
	pipe_drive_a: assert property (@(posedge mclk) disable iff (rst)
		rd_w && byte_w == 2'h3 ##1 sel_w ##1
		output_latency_sel && !out_enable_n |-> data_oe == 2'h3)
		else $error("pipelined read not driven after two selects");
	pipe_byte_a: assert property (@(posedge mclk) disable iff (rst)
		rd_w && upper_byte_sel_n ##1 sel_w ##1 output_latency_sel
		|-> !data_oe[1])
		else $error("pipelined upper byte not floated");
	write_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		sel_w && !write_n ##1 !output_latency_sel |-> data_oe == 2'h0)
		else $error("drivers on after a write cycle");

	// Scenarios
	burst_c: cover property (@(posedge mclk) disable iff (rst)
		!addr_load_strobe_n ##1 !count_advance_n [*3]);
	pipe_read_c: cover property (@(posedge mclk) disable iff (rst)
		output_latency_sel && rd_w ##2 data_oe == 2'h3);
	clear_rw_c: cover property (@(posedge mclk) disable iff (rst)
		!count_clear_n && we_w == 2'h3);
	desel_c: cover property (@(posedge mclk) disable iff (rst)
		!sel_w ##1 low_power);
	adv_write_c: cover property (@(posedge mclk) disable iff (rst)
		!count_advance_n && addr_load_strobe_n && we_w != 2'h0);
endmodule // sync_dual_port_ram_counter_port

/* sim/port_b_master.sv */
// Far-side master model that drives the second port
`timescale 1ns/1ps
module port_b_master
	import dpram_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// Requests from the bench
	input  wire logic              go,
	input  wire logic              rd,
	input  wire logic [ADDR_W-1:0] pa,
	input  wire logic [DATA_W-1:0] pd,
	// Second port pins
	output logic                   b_rd,
	output logic      [1:0]        b_we,
	output logic      [ADDR_W-1:0] b_addr,
	output logic      [DATA_W-1:0] b_wdata
);
	// Address, data and control launched together on one edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			b_rd    <= 1'b0;
			b_we    <= 2'h0;
			b_addr  <= '0;
			b_wdata <= '0;
		end else begin
			b_rd    <= rd;
			b_we    <= go ? 2'h3 : 2'h0;
			b_addr  <= pa;
			b_wdata <= go ? pd : ~b_wdata; // Released data keeps moving
		end
	end
endmodule // port_b_master

/* sim/sync_dual_port_ram_counter_port_tb.sv */
// Directed bench for the counter port and the second port
`timescale 1ns/1ps
module sync_dual_port_ram_counter_port_tb;
	import dpram_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, go = 1'b0, rd = 1'b0;
	logic addr_load_strobe_n = 1'b1, count_advance_n = 1'b1;
	logic count_clear_n = 1'b1, chip_sel_low_n = 1'b0, chip_sel_high = 1'b1;
	logic write_n = 1'b1, upper_byte_sel_n = 1'b0, lower_byte_sel_n = 1'b0;
	logic out_enable_n = 1'b0, output_latency_sel = 1'b0, low_power, b_rd;
	logic [ADDR_W-1:0] ext_addr = '0, int_addr, b_addr, pa = '0;
	logic [DATA_W-1:0] data_in = '0, data_out, b_wdata, b_rdata, pd = '0;
	logic [1:0]        data_oe, b_we;
	int                n_mismatch = 0, comparisons = 0;
	sync_dual_port_ram_counter_port sync_dual_port_ram_counter_port_inst (.*);
	port_b_master port_b_master_inst (.*);
	always #2.5 mclk = ~mclk;
	// One cycle on the counter port, sampled at the following edge
	task automatic cyc(input logic ld, adv, clr, wr, input logic [1:0] sel,
		bs, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		addr_load_strobe_n <= ld;
		count_advance_n    <= adv;
		count_clear_n      <= clr;
		write_n            <= wr;
		{chip_sel_low_n, chip_sel_high} <= sel; // One bank at a time
		{upper_byte_sel_n, lower_byte_sel_n} <= bs;
		ext_addr           <= a;
		data_in            <= d;
		#1;
	endtask
	task automatic hold();
		cyc(1'b1, 1'b1, 1'b1, 1'b1, 2'h1, 2'h0, '0, '0);
	endtask
	task automatic bport(input logic g, r, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge mclk);
		go <= g;
		rd <= r;
		pa <= a;
		pd <= d;
		#1;
	endtask
	task automatic cmp(input logic [DATA_W-1:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Cuts a hang short
	initial begin
		repeat (3000) @(posedge mclk);
		n_mismatch++;
		conclude();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0, 15'h0005, 18'h12345);
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 2'h0, 15'h0005, '0);
		hold();
		cmp(data_out, 18'h12345);
		cmp(DATA_W'(data_oe), 18'h00003);
		cyc(1'b0, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0, 15'h000A, 18'h0AAAA);
		cyc(1'b1, 1'b0, 1'b1, 1'b0, 2'h1, 2'h0, 15'h0005, 18'h2BBBB);
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 2'h0, 15'h000B, '0);
		hold();
		cmp(data_out, 18'h2BBBB);
		for (int i = 0; i < 3; i++) begin
			hold();
			cmp(data_out, 18'h2BBBB);
			cmp(DATA_W'(int_addr), 18'h0000B);
		end
		cyc(1'b1, 1'b1, 1'b0, 1'b0, 2'h1, 2'h0, '0, 18'h1C0DE);
		cyc(1'b0, 1'b1, 1'b0, 1'b1, 2'h1, 2'h2, 15'h0005, '0);
		hold();
		cmp(data_out, 18'h1C0DE);
		cmp(DATA_W'(int_addr), '0);
		cmp(DATA_W'(data_oe), 18'h00001);
		for (int s = 0; s < 2; s++) begin
			cyc(1'b1, 1'b1, 1'b1, 1'b1, s ? 2'h3 : 2'h0, 2'h0, '0, '0);
			hold();
			cmp(DATA_W'(low_power), 18'h00001);
			cmp(DATA_W'(data_oe), '0);
			hold();
		end
		@(posedge mclk);
		out_enable_n <= 1'b1;
		#1;
		cmp(DATA_W'(data_oe), '0);
		@(posedge mclk);
		out_enable_n       <= 1'b0;
		output_latency_sel <= 1'b1;
		cyc(1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0, '0, '0);
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 2'h0, 15'h0005, '0);
		hold();
		cmp(DATA_W'(data_oe), '0);
		hold();
		cmp(data_out, 18'h12345);
		cmp(DATA_W'(data_oe), 18'h00003);
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 2'h2, 15'h0005, '0);
		hold();
		hold();
		cmp(DATA_W'(data_oe), 18'h00001);
		bport(1'b1, 1'b0, 15'h0014, 18'h3F00D);
		bport(1'b0, 1'b0, 15'h0014, '0);
		bport(1'b0, 1'b1, 15'h0005, '0);
		bport(1'b0, 1'b0, 15'h0005, '0);
		bport(1'b0, 1'b0, 15'h0005, '0);
		cmp(b_rdata, 18'h12345);
		@(posedge mclk);
		output_latency_sel <= 1'b0;
		cyc(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 2'h0, 15'h0014, '0);
		hold();
		cmp(data_out, 18'h3F00D);
		conclude();
	end
endmodule // sync_dual_port_ram_counter_port_tb
